// >>> rid_pkg.sv
package rid_pkg;
  // widths of the datapath
  localparam int DATA_W = 8;
  localparam int PC_W = 9;
  localparam int INSTR_W = 12;
  localparam int FILE_COUNT = 32;
  localparam int STACK_DEPTH = 2;

  // one instruction cycle is four oscillator periods of ref_clk
  localparam int OSC_PER_INSTR = 4;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_INSTR - 1);

  // special file addresses
  localparam logic [4:0] FA_TIMER = 5'h01;
  localparam logic [4:0] FA_PCL = 5'h02;
  localparam logic [4:0] FA_STATUS = 5'h03;
  localparam logic [4:0] FA_PORT_A = 5'h05;
  localparam logic [4:0] FA_PORT_B = 5'h06;

  // status bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_DIGIT_CARRY = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_POWER_DOWN = 3;
  localparam int ST_TIME_OUT = 4;
  localparam int ST_PIN_WAKE = 7;
  // prescaler assignment bit in the option register: 0 means timer
  localparam int OPT_PSA = 3;

  // values after reset
  localparam logic [7:0] STATUS_RST = 8'h98;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [8:0] PC_RST = 9'h1ff;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // apb register byte addresses
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATE = 12'h004;
  localparam logic [11:0] REG_OPTION = 12'h008;
  localparam int CTRL_RUN = 0;
  localparam int STATE_SLEEP = 12;
endpackage : rid_pkg

// >>> rid_core.sv
// Notes on behaviour
// - add accumulator and file in one cycle, update carry, digit carry, zero
// - destination bit 0 writes accumulator, 1 writes the addressed file
// - and/or/xor accumulator with file in one cycle, zero flag only
// - and/or/xor literal into accumulator, zero flag updated
// - rotate file through carry, nine bits, one cycle, carry only
// - decrement, store, skip next on zero, two cycles when skipping
// - increment, store, skip next on zero, two cycles when skipping
// - skip next when selected bit is clear, two cycles when skipping
// - skip next when selected bit is set, two cycles when skipping
// - return loads literal into accumulator, pops stack, two cycles
// - jump loads nine-bit target into program counter, two cycles
// - call, return and pc-low writes clear bit 8; jump loads all nine bits
// - port registers read pin levels, not output latches
// - direction load copies accumulator to port A or B direction latch
// - direction bit 1 releases pin, 0 drives it
// - writing timer register clears prescaler when assigned to timer
// - sleep enters standby, sets time-out and pin wake, clears power-down
// - watchdog clear resets watchdog, sets time-out and power-down
// - option load copies accumulator into option register, no flags
// - instruction cycle is four clocks; branches and taken skips take two
// - five-bit file field selects one of 32 file registers
`timescale 1ns/100ps
module rid_core (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [8:0] progAddr,
  input wire logic [11:0] progData,
  input wire logic [7:0] portAIn,
  output logic [7:0] portAOut,
  output logic [7:0] portAOe,
  input wire logic [7:0] portBIn,
  output logic [7:0] portBOut,
  output logic [7:0] portBOe,
  output logic [7:0] optionOut,
  output logic wdtClear,
  output logic prescalerClear,
  output logic sleepMode
);
  logic [1:0] phase_r;
  logic cycEn;
  logic [31:0] ctrl_r;
  logic [8:0] pc_r;
  logic dead_r;
  logic [8:0] stack_r [rid_pkg::STACK_DEPTH];
  logic [7:0] acc_r;
  logic [7:0] status_r;
  logic [7:0] option_r;
  logic [7:0] timer_r;
  logic [7:0] gpr_r [rid_pkg::FILE_COUNT];
  logic [7:0] latA_r, latB_r, dirA_r, dirB_r;
  logic [7:0] syncA1_r, syncA2_r, syncA3_r, pinA_r;
  logic [7:0] syncB1_r, syncB2_r, syncB3_r, pinB_r;
  logic sleep_r, wdtClear_r, preClr_r;
  logic execOk;
  logic [11:0] instr;
  logic [4:0] fAddr;
  logic [2:0] bitIdx;
  logic [7:0] lit;
  logic [7:0] fVal;
  logic [8:0] pcInc;
  logic [8:0] sum9, sub9;
  logic [4:0] sumLo, subLo;
  logic [7:0] resV;
  logic wrFile, wrAcc, zEn, cEn, dcEn, cV, dcV;
  logic branch, skipTake, doCall, doRet, doOpt, doSleep, doWdt, dirLdA, dirLdB;
  logic [8:0] pcTgt;
  logic timerWrite;

  // instruction cycle enable: one pulse every four clocks, the only slower rate
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign cycEn = (phase_r == rid_pkg::PHASE_LAST);

  // pins are asynchronous: three stages, accept a level once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syncA1_r <= 8'h00;
      syncA2_r <= 8'h00;
      syncA3_r <= 8'h00;
      pinA_r <= 8'h00;
      syncB1_r <= 8'h00;
      syncB2_r <= 8'h00;
      syncB3_r <= 8'h00;
      pinB_r <= 8'h00;
    end else begin
      syncA1_r <= portAIn;
      syncA2_r <= syncA1_r;
      syncA3_r <= syncA2_r;
      syncB1_r <= portBIn;
      syncB2_r <= syncB1_r;
      syncB3_r <= syncB2_r;
      for (int i = 0; i < 8; i++) begin
        if (syncA2_r[i] == syncA3_r[i]) begin
          pinA_r[i] <= syncA3_r[i];
        end
        if (syncB2_r[i] == syncB3_r[i]) begin
          pinB_r[i] <= syncB3_r[i];
        end
      end
    end
  end

  // decode fields
  assign instr = progData;
  assign fAddr = instr[4:0];
  assign bitIdx = instr[7:5];
  assign lit = instr[7:0];
  assign pcInc = pc_r + 9'h001;
  assign execOk = cycEn && ctrl_r[rid_pkg::CTRL_RUN] && !sleep_r && !dead_r;

  // file read mux; ports return the pin level so read-modify-write sees the pins
  always_comb begin
    unique case (fAddr)
      rid_pkg::FA_TIMER: fVal = timer_r;
      rid_pkg::FA_PCL: fVal = pc_r[7:0];
      rid_pkg::FA_STATUS: fVal = status_r;
      rid_pkg::FA_PORT_A: fVal = pinA_r;
      rid_pkg::FA_PORT_B: fVal = pinB_r;
      default: fVal = gpr_r[fAddr];
    endcase
  end

  // adder and subtractor share the decode; digit carry taken from the low nibbles
  assign sum9 = {1'b0, acc_r} + {1'b0, fVal};
  assign sub9 = {1'b0, fVal} - {1'b0, acc_r};
  assign sumLo = {1'b0, acc_r[3:0]} + {1'b0, fVal[3:0]};
  assign subLo = {1'b0, fVal[3:0]} - {1'b0, acc_r[3:0]};

  // main decoder: result, destination, flag enables and program flow
  always_comb begin
    resV = 8'h00;
    wrFile = 1'b0;
    wrAcc = 1'b0;
    zEn = 1'b0;
    cEn = 1'b0;
    dcEn = 1'b0;
    cV = 1'b0;
    dcV = 1'b0;
    branch = 1'b0;
    pcTgt = pcInc;
    skipTake = 1'b0;
    doCall = 1'b0;
    doRet = 1'b0;
    doOpt = 1'b0;
    doSleep = 1'b0;
    doWdt = 1'b0;
    dirLdA = 1'b0;
    dirLdB = 1'b0;
    unique casez (instr[11:6])
      6'b000000: begin
        if (instr[5]) begin
          resV = acc_r; // move accumulator to file
          wrFile = 1'b1;
        end else if (instr[4:0] == 5'h02) begin
          doOpt = 1'b1;
        end else if (instr[4:0] == 5'h03) begin
          doSleep = 1'b1;
        end else if (instr[4:0] == 5'h04) begin
          doWdt = 1'b1;
        end else if (instr[4:0] == 5'h05) begin
          dirLdA = 1'b1;
        end else if (instr[4:0] == 5'h06) begin
          dirLdB = 1'b1;
        end
      end
      6'b000001: begin
        resV = 8'h00; // clear file when bit 5 set, clear accumulator otherwise
        wrFile = instr[5];
        wrAcc = !instr[5];
        zEn = 1'b1;
      end
      6'b000010: begin
        resV = sub9[7:0];
        cEn = 1'b1;
        cV = !sub9[8];
        dcEn = 1'b1;
        dcV = !subLo[4];
        zEn = 1'b1;
      end
      6'b000011: begin
        resV = fVal - 8'h01;
        zEn = 1'b1;
      end
      6'b000100: begin
        resV = acc_r | fVal;
        zEn = 1'b1;
      end
      6'b000101: begin
        resV = acc_r & fVal;
        zEn = 1'b1;
      end
      6'b000110: begin
        resV = acc_r ^ fVal;
        zEn = 1'b1;
      end
      6'b000111: begin
        resV = sum9[7:0];
        cEn = 1'b1;
        cV = sum9[8];
        dcEn = 1'b1;
        dcV = sumLo[4];
        zEn = 1'b1;
      end
      6'b001000: begin
        resV = fVal;
        zEn = 1'b1;
      end
      6'b001001: begin
        resV = ~fVal;
        zEn = 1'b1;
      end
      6'b001010: begin
        resV = fVal + 8'h01;
        zEn = 1'b1;
      end
      6'b001011: begin
        resV = fVal - 8'h01;
        skipTake = (resV == 8'h00);
      end
      6'b001100: begin
        resV = {status_r[rid_pkg::ST_CARRY], fVal[7:1]};
        cEn = 1'b1;
        cV = fVal[0];
      end
      6'b001101: begin
        resV = {fVal[6:0], status_r[rid_pkg::ST_CARRY]};
        cEn = 1'b1;
        cV = fVal[7];
      end
      6'b001110: begin
        resV = {fVal[3:0], fVal[7:4]};
      end
      6'b001111: begin
        resV = fVal + 8'h01;
        skipTake = (resV == 8'h00);
      end
      6'b0100??: begin
        resV = fVal & ~(8'h01 << bitIdx);
        wrFile = 1'b1;
      end
      6'b0101??: begin
        resV = fVal | (8'h01 << bitIdx);
        wrFile = 1'b1;
      end
      6'b0110??: begin
        skipTake = !fVal[bitIdx];
      end
      6'b0111??: begin
        skipTake = fVal[bitIdx];
      end
      6'b1000??: begin
        resV = lit;
        wrAcc = 1'b1;
        doRet = 1'b1;
        branch = 1'b1;
        pcTgt = {1'b0, stack_r[0][7:0]};
      end
      6'b1001??: begin
        doCall = 1'b1;
        branch = 1'b1;
        pcTgt = {1'b0, lit};
      end
      6'b101???: begin
        branch = 1'b1;
        pcTgt = instr[8:0];
      end
      6'b1100??: begin
        resV = lit;
        wrAcc = 1'b1;
      end
      6'b1101??: begin
        resV = acc_r | lit;
        wrAcc = 1'b1;
        zEn = 1'b1;
      end
      6'b1110??: begin
        resV = acc_r & lit;
        wrAcc = 1'b1;
        zEn = 1'b1;
      end
      6'b1111??: begin
        resV = acc_r ^ lit;
        wrAcc = 1'b1;
        zEn = 1'b1;
      end
    endcase
    // byte ops with a destination bit: 1 to file, 0 to accumulator
    if (instr[11:10] == 2'b00 && instr[11:6] > 6'b000001) begin
      wrFile = instr[5];
      wrAcc = !instr[5];
    end
  end

  assign timerWrite = wrFile && (fAddr == rid_pkg::FA_TIMER);

  // program counter, dead cycle after any flow change, return stack
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pc_r <= rid_pkg::PC_RST;
      dead_r <= 1'b0;
      for (int i = 0; i < rid_pkg::STACK_DEPTH; i++) begin
        stack_r[i] <= 9'h000;
      end
    end else if (cycEn && dead_r) begin
      dead_r <= 1'b0; // second cycle of a two-cycle instruction
    end else if (execOk) begin
      if (wrFile && fAddr == rid_pkg::FA_PCL) begin
        pc_r <= {1'b0, resV};
        dead_r <= 1'b1;
      end else if (branch) begin
        pc_r <= pcTgt;
        dead_r <= 1'b1;
      end else if (skipTake) begin
        pc_r <= pc_r + 9'h002; // skipped word is never executed, costs a cycle
        dead_r <= 1'b1;
      end else begin
        pc_r <= pcInc;
      end
      if (doCall) begin
        for (int i = rid_pkg::STACK_DEPTH - 1; i > 0; i--) begin
          stack_r[i] <= stack_r[i - 1];
        end
        stack_r[0] <= pcInc;
      end else if (doRet) begin
        for (int i = 0; i < rid_pkg::STACK_DEPTH - 1; i++) begin
          stack_r[i] <= stack_r[i + 1];
        end
      end
    end
  end

  // accumulator and status; hardware flag updates override a software write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_r <= 8'h00;
      status_r <= rid_pkg::STATUS_RST;
    end else if (execOk) begin
      if (wrAcc) begin
        acc_r <= resV;
      end
      if (wrFile && fAddr == rid_pkg::FA_STATUS) begin
        status_r[6:5] <= resV[6:5];
        status_r[2:0] <= resV[2:0];
      end
      if (zEn) begin
        status_r[rid_pkg::ST_ZERO] <= (resV == 8'h00);
      end
      if (cEn) begin
        status_r[rid_pkg::ST_CARRY] <= cV;
      end
      if (dcEn) begin
        status_r[rid_pkg::ST_DIGIT_CARRY] <= dcV;
      end
      if (doSleep) begin
        status_r[rid_pkg::ST_TIME_OUT] <= 1'b1;
        status_r[rid_pkg::ST_POWER_DOWN] <= 1'b0;
        status_r[rid_pkg::ST_PIN_WAKE] <= 1'b1;
      end
      if (doWdt) begin
        status_r[rid_pkg::ST_TIME_OUT] <= 1'b1;
        status_r[rid_pkg::ST_POWER_DOWN] <= 1'b1;
      end
    end
  end

  // file registers, timer storage, port latches, direction latches, option
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < rid_pkg::FILE_COUNT; i++) begin
        gpr_r[i] <= 8'h00;
      end
      timer_r <= 8'h00;
      latA_r <= 8'h00;
      latB_r <= 8'h00;
      dirA_r <= rid_pkg::DIR_RST;
      dirB_r <= rid_pkg::DIR_RST;
      option_r <= rid_pkg::OPTION_RST;
    end else if (execOk) begin
      if (wrFile) begin
        unique case (fAddr)
          rid_pkg::FA_TIMER: timer_r <= resV;
          rid_pkg::FA_PCL, rid_pkg::FA_STATUS: begin
          end
          rid_pkg::FA_PORT_A: latA_r <= resV;
          rid_pkg::FA_PORT_B: latB_r <= resV;
          default: gpr_r[fAddr] <= resV;
        endcase
      end
      if (dirLdA) begin
        dirA_r <= acc_r;
      end
      if (dirLdB) begin
        dirB_r <= acc_r;
      end
      if (doOpt) begin
        option_r <= acc_r;
      end
    end
  end

  // one-cycle pulses to the watchdog and prescaler, standby held until reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wdtClear_r <= 1'b0;
      preClr_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      wdtClear_r <= execOk && (doWdt || doSleep);
      preClr_r <= execOk && timerWrite && !option_r[rid_pkg::OPT_PSA];
      if (execOk && doSleep) begin
        sleep_r <= 1'b1;
      end
    end
  end

  assign progAddr = pc_r;
  assign portAOut = latA_r;
  assign portBOut = latB_r;
  assign portAOe = ~dirA_r;
  assign portBOe = ~dirB_r;
  assign optionOut = option_r;
  assign wdtClear = wdtClear_r;
  assign prescalerClear = preClr_r;
  assign sleepMode = sleep_r;

  // apb slave: zero wait states, read data captured in the setup cycle
  logic mapped;
  assign mapped = (paddr == rid_pkg::REG_CTRL) || (paddr == rid_pkg::REG_STATE) ||
                  (paddr == rid_pkg::REG_OPTION);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= rid_pkg::CTRL_RST;
      prdata <= 32'h0000_0000;
    end else begin
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          rid_pkg::REG_CTRL: prdata <= {31'h0000_0000, ctrl_r[rid_pkg::CTRL_RUN]};
          rid_pkg::REG_STATE: prdata <= {status_r, acc_r, 3'h0, sleep_r, dead_r, 2'h0, pc_r};
          rid_pkg::REG_OPTION: prdata <= {24'h00_0000, option_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (psel && penable && pwrite && paddr == rid_pkg::REG_CTRL) begin
        ctrl_r <= {31'h0000_0000, pwdata[rid_pkg::CTRL_RUN]};
      end
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_add_sum: assert property (execOk && instr[11:6] == 6'b000111 && !instr[5] |=>
    acc_r == $past(sum9[7:0]) && status_r[rid_pkg::ST_CARRY] == $past(sum9[8]))
    else $error("add result or carry wrong");
  a_dest_file: assert property (execOk && instr[11:7] == 5'b00011 && instr[5] |=>
    $stable(acc_r)) else $error("file destination changed accumulator");
  a_literal_zero: assert property (execOk && instr[11:8] == 4'b1110 |=>
    status_r[rid_pkg::ST_ZERO] == ((acc_r) == 8'h00)) else $error("zero flag wrong after and literal");
  a_rotate_carry: assert property (execOk && instr[11:6] == 6'b001101 |=>
    status_r[rid_pkg::ST_CARRY] == $past(fVal[7])) else $error("rotate left carry wrong");
  a_skip_two: assert property (execOk && skipTake |=> dead_r ##4 !dead_r)
    else $error("taken skip did not cost one dead cycle");
  a_jump_target: assert property (execOk && instr[11:9] == 3'b101 |=>
    pc_r == $past(instr[8:0]) && dead_r) else $error("jump target wrong");
  a_call_bit8: assert property (execOk && instr[11:8] == 4'b1001 |=> !pc_r[8])
    else $error("call left program counter bit 8 set");
  a_dir_load: assert property (execOk && instr == 12'h005 |=> portAOe == ~$past(acc_r))
    else $error("direction load to port A wrong");
  a_presc_clear: assert property (execOk && timerWrite && !option_r[rid_pkg::OPT_PSA] |=>
    prescalerClear ##1 !prescalerClear) else $error("prescaler clear pulse wrong");
  a_sleep_flags: assert property (execOk && instr == 12'h003 |=> sleepMode &&
    !status_r[rid_pkg::ST_POWER_DOWN] && status_r[rid_pkg::ST_TIME_OUT] && wdtClear)
    else $error("sleep flags wrong");
  a_cycle_rate: assert property (cycEn |=> !cycEn [*3] ##1 cycEn)
    else $error("instruction cycle not four clocks");
endmodule : rid_core

// >>> rid_prog_mem.sv
`timescale 1ns/100ps
// program store on the far side of the core; the bench loads words one per clock
module rid_prog_mem (
  input wire logic ref_clk,
  input wire logic ldEn,
  input wire logic [8:0] ldAddr,
  input wire logic [11:0] ldData,
  input wire logic [8:0] progAddr,
  output logic [11:0] progData
);
  logic [11:0] memR [0:511];

  // empty words read as no-op so a stray fetch never shows unknowns
  initial begin
    for (int i = 0; i < 512; i++) memR[i] = 12'h000;
  end

  // load port, used only while the core is held in reset or sits in standby after its closing sleep
  always @(posedge ref_clk) begin
    if (ldEn) memR[ldAddr] <= ldData;
  end

  // combinational read so the word always matches the program counter
  assign progData = memR[progAddr];
endmodule : rid_prog_mem

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, wdtClear, prescalerClear, sleepMode;
  logic [11:0] paddr, progData, ldData;
  logic [31:0] pwdata, prdata, rdat, stateR;
  logic [8:0] progAddr, ldAddr;
  logic [7:0] portAIn, portAOut, portAOe, portBIn, portBOut, portBOe, optionOut;
  logic ldEn, rerr;
  int errors, nChecks, nWdt, nPre;

  rid_core DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .progAddr(progAddr), .progData(progData), .portAIn(portAIn), .portAOut(portAOut),
    .portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
    .optionOut(optionOut), .wdtClear(wdtClear), .prescalerClear(prescalerClear), .sleepMode(sleepMode));

  rid_prog_mem u_mem (.ref_clk(ref_clk), .ldEn(ldEn), .ldAddr(ldAddr), .ldData(ldData),
    .progAddr(progAddr), .progData(progData));

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // pulse counters, cleared while reset is low so each scenario starts fresh
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      nWdt <= 0;
      nPre <= 0;
    end else begin
      if (wdtClear === 1'b1) nWdt <= nWdt + 1;
      if (prescalerClear === 1'b1) nPre <= nPre + 1;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task print_verdict;
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // one apb transfer; entered just after a rising edge, holds until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  // load enable stays up across back-to-back loads; go() drops it
  task ld(input logic [8:0] a, input logic [11:0] w);
    ldEn <= 1'b1;
    ldAddr <= a;
    ldData <= w;
    @(posedge ref_clk);
  endtask : ld

  // reset vector jumps to 0, then the program follows from address 0
  task prog(input logic [11:0] q[$]);
    ld(9'h1ff, 12'ha00);
    foreach (q[i]) ld(9'(i), q[i]);
  endtask : prog

  // reset, start the core, wait for the closing sleep, then fetch the state word
  task go;
    int n;
    ldEn <= 1'b0;
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b1, rid_pkg::REG_CTRL, 32'h0000_0001);
    n = 0;
    while (sleepMode !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, sleepMode}, 32'h1, "standby not reached");
    repeat (2) @(posedge ref_clk);
    apb(1'b0, rid_pkg::REG_STATE, 32'h0);
    stateR = rdat;
  endtask : go

  task t_add;
    prog('{12'hcff, 12'h030, 12'hc01, 12'h1f0, 12'h210, 12'h003});
    go();
    chk(stateR[23:16], 8'h00, "add to file then move");
    chk(stateR[31:24], 8'h97, "add carry flags");
    prog('{12'hc17, 12'h031, 12'hc2c, 12'h1d1, 12'h003});
    go();
    chk(stateR[23:16], 8'h43, "add into acc");
    chk(stateR[31:24], 8'h92, "add digit carry only");
  endtask : t_add

  // every logical op, file and literal forms, acc = 8'h5c op 8'ha3
  task t_logic;
    logic [11:0] ops[6];
    logic [7:0] e;
    ops = '{12'h150, 12'h110, 12'h190, 12'hea3, 12'hda3, 12'hfa3};
    for (int i = 0; i < 6; i++) begin
      e = (i % 3 == 0) ? 8'h00 : 8'hff;
      prog('{12'hca3, 12'h030, 12'hc5c, ops[i], 12'h003});
      go();
      chk(stateR[23:16], e, "logic result");
      chk(stateR[31:24], {5'b10010, (e == 8'h00), 2'b00}, "logic zero flag");
    end
  endtask : t_logic

  task t_rotate;
    prog('{12'hc81, 12'h030, 12'h350, 12'h330, 12'h210, 12'h003});
    go();
    chk(stateR[23:16], 8'hc0, "rotate through carry");
    chk(stateR[31:24], 8'h91, "rotate carry");
  endtask : t_rotate

  // skipped words would set other acc bits
  task t_skip;
    prog('{12'hc01, 12'h030, 12'h2d0, 12'hc55, 12'h3f0, 12'hd80, 12'h730, 12'hd01,
      12'h610, 12'hd02, 12'h630, 12'hd04, 12'h003});
    go();
    chk(stateR[23:16], 8'h84, "skip sequence");
    chk(stateR[31:24], 8'h90, "skips leave flags");
  endtask : t_skip

  // a return that kept pc bit 8 would land on the 8'h99 load
  task t_call;
    prog('{12'h000, 12'h003});
    ld(9'h1ff, 12'hb00);
    ld(9'h100, 12'h920);
    ld(9'h101, 12'hc99);
    ld(9'h102, 12'h003);
    ld(9'h020, 12'h83c);
    go();
    chk(stateR[23:16], 8'h3c, "call return literal");
  endtask : t_call

  // the decrement of port A reads the pins; a latch read would wrap 8'h00 to 8'hff
  task t_ports;
    portBIn <= 8'h5a;
    portAIn <= 8'hc3;
    prog('{12'hcf0, 12'h006, 12'hc0f, 12'h005, 12'hc37, 12'h002, 12'hcff, 12'h026, 12'h226, 12'h0e5, 12'h003});
    go();
    chk(portAOut, 8'hc2, "port a from pins");
    chk(portBOe, 8'h0f, "port b enables");
    chk(portAOe, 8'hf0, "port a enables");
    chk(portBOut, 8'h5a, "port b from pins");
    chk(optionOut, 8'h37, "option load");
    apb(1'b0, rid_pkg::REG_OPTION, 32'h0);
    chk(rdat, 32'h37, "option readback");
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
  endtask : t_ports

  // clear only once prescaler belongs to timer, and only on a file write
  task t_timer;
    prog('{12'h021, 12'h004, 12'hc00, 12'h002, 12'h021, 12'h201, 12'h003});
    go();
    chk(32'(nPre), 32'd1, "prescaler clears");
    chk(32'(nWdt), 32'd2, "watchdog clears");
    chk(stateR[31:24], 8'h94, "sleep flags");
  endtask : t_timer

  // subtract, swap, complement, increment, bit clear and set, clear file, then a pc-low write to 8'h2f
  task t_misc;
    prog('{12'hc3a, 12'h030, 12'hc15, 12'h0b0, 12'h3b0, 12'h270, 12'h2b0, 12'h4f0, 12'h510, 12'h210,
      12'h070, 12'h022, 12'hc00, 12'h003});
    ld(9'h02f, 12'h003);
    go();
    chk(stateR[23:16], 8'h2f, "byte and bit ops then pc low write");
    chk(stateR[31:24], 8'h97, "subtract carries and clear zero");
  endtask : t_misc

  // hang guard, far beyond the fewer than one thousand clock cycles the scenarios need
  initial begin
    #400000;
    errors++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    portAIn = 8'h00;
    portBIn = 8'h00;
    ldEn = 1'b0;
    ldAddr = 9'h000;
    ldData = 12'h000;
    errors = 0;
    nChecks = 0;
    @(posedge ref_clk);
    t_add();
    t_logic();
    t_rotate();
    t_skip();
    t_call();
    t_ports();
    t_timer();
    t_misc();
    print_verdict();
  end
endmodule : tb_top
